// >>> inc/seh_pkg.sv
// Shared constants for the status event hierarchy.
package seh_pkg;
    localparam int DW = 16;
    localparam int ESR_W = 8;
    localparam int STB_W = 8;
    localparam int ERRQ_DEPTH = 8;

    // Register selectors on the access port.
    localparam logic [2:0] SEL_QUESTIONABLE_SUMMARY = 3'h0;
    localparam logic [2:0] SEL_OPERATION_SUMMARY = 3'h1;
    localparam logic [2:0] SEL_STD = 3'h2;
    localparam logic [2:0] SEL_STB = 3'h3;
    localparam logic [2:0] SEL_ERRQ = 3'h4;

    // Part selectors within one status register.
    localparam logic [2:0] PART_LIVE = 3'h0;
    localparam logic [2:0] PART_RISE = 3'h1;
    localparam logic [2:0] PART_FALL = 3'h2;
    localparam logic [2:0] PART_EVENT = 3'h3;
    localparam logic [2:0] PART_MASK = 3'h4;

    // Reset values of the writable and latched parts.
    localparam logic [DW-1:0] RISE_RST = 16'h7FFF;
    localparam logic [DW-1:0] FALL_RST = 16'h0000;
    localparam logic [DW-1:0] EVENT_RST = 16'h0000;
    localparam logic [DW-1:0] MASK_RST = 16'h0000;
    localparam logic [ESR_W-1:0] ESR_RST = 8'h00;
    localparam logic [STB_W-1:0] SRE_RST = 8'h00;

    // Bit positions in the top status byte.
    localparam int STB_ERRQ = 2;
    localparam int STB_QUESTIONABLE_SUMMARY = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam int STB_OPERATION_SUMMARY = 7;
    localparam logic [STB_W-1:0] SRE_WMASK = 8'hBF;
endpackage : seh_pkg

// >>> hdl/seh_status_reg.sv
// One five-part status register with edge filters and summary bit.
`timescale 1ns/100ps
module seh_status_reg #(
    parameter int W = seh_pkg::DW
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [W-2:0] cond_in,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [2:0] part,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] rdata,
    output logic summary
);
    logic [W-2:0] prev_r, prev_nxt;
    logic [W-2:0] rise_r, rise_nxt;
    logic [W-2:0] fall_r, fall_nxt;
    logic [W-2:0] evt_r, evt_nxt;
    logic [W-2:0] mask_r, mask_nxt;
    logic [W-2:0] rise_hit, fall_hit;
    logic evt_rd;

    assign rise_hit = cond_in & ~prev_r & rise_r;
    assign fall_hit = ~cond_in & prev_r & fall_r;
    assign evt_rd = rd_en && (part == seh_pkg::PART_EVENT);
    assign summary = |(evt_r & mask_r);

    always_comb begin
        prev_nxt = cond_in;
        rise_nxt = rise_r;
        fall_nxt = fall_r;
        mask_nxt = mask_r;
        // A filtered edge in the read cycle survives the clear.
        evt_nxt = evt_rd ? (rise_hit | fall_hit)
                         : (evt_r | rise_hit | fall_hit);
        if (wr_en) begin
            case (part)
                seh_pkg::PART_RISE: rise_nxt = wdata[W-2:0];
                seh_pkg::PART_FALL: fall_nxt = wdata[W-2:0];
                seh_pkg::PART_MASK: mask_nxt = wdata[W-2:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        case (part)
            seh_pkg::PART_LIVE: rdata = {1'b0, cond_in};
            seh_pkg::PART_RISE: rdata = {1'b0, rise_r};
            seh_pkg::PART_FALL: rdata = {1'b0, fall_r};
            seh_pkg::PART_EVENT: rdata = {1'b0, evt_r};
            seh_pkg::PART_MASK: rdata = {1'b0, mask_r};
            default: rdata = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prev_r <= '0;
            rise_r <= seh_pkg::RISE_RST[W-2:0];
            fall_r <= seh_pkg::FALL_RST[W-2:0];
            evt_r <= seh_pkg::EVENT_RST[W-2:0];
            mask_r <= seh_pkg::MASK_RST[W-2:0];
        end else begin
            prev_r <= prev_nxt;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
            evt_r <= evt_nxt;
            mask_r <= mask_nxt;
        end
    end

    sequence rise_seen;
        (rise_hit != '0);
    endsequence
    sequence fall_seen;
        (fall_hit != '0);
    endsequence

    rise_latch_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        rise_seen |=> ((evt_r & $past(rise_hit)) == $past(rise_hit)))
        else $error("Filtered rising edge not latched.");
    fall_latch_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        fall_seen |=> ((evt_r & $past(fall_hit)) == $past(fall_hit)))
        else $error("Filtered falling edge not latched.");
    event_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !evt_rd |=> ((evt_r & $past(evt_r)) == $past(evt_r)))
        else $error("Latched event lost without a read.");
    event_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        evt_rd |=> (evt_r == ($past(rise_hit) | $past(fall_hit))))
        else $error("Event part not cleared by read.");
    live_readonly_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (wr_en && part == seh_pkg::PART_LIVE)
        |=> ($stable(rise_r) && $stable(fall_r) && $stable(mask_r)))
        else $error("Write to live part changed state.");
    msb_zero_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        rdata[W-1] == 1'b0)
        else $error("Top bit of a part read as one.");
endmodule : seh_status_reg

// >>> hdl/seh_err_queue.sv
// Oldest-first error and event queue.
`timescale 1ns/100ps
module seh_err_queue #(
    parameter int W = seh_pkg::DW,
    parameter int DEPTH = seh_pkg::ERRQ_DEPTH
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic push,
    input wire logic [W-1:0] push_data,
    input wire logic pop,
    output logic not_empty,
    output logic full,
    output logic [W-1:0] head
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [W-1:0] mem_nxt [DEPTH];
    logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic do_push, do_pop;

    assign not_empty = (wp_r != rp_r);
    assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    assign head = mem_r[rp_r[AW-1:0]];
    // New entries are dropped while full so older history is never lost.
    assign do_push = push && !full;
    assign do_pop = pop && not_empty;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        if (do_push) begin
            mem_nxt[wp_r[AW-1:0]] = push_data;
            wp_nxt = wp_r + 1'b1;
        end
        if (do_pop) begin
            rp_nxt = rp_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wp_r <= '0;
            rp_r <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            mem_r <= mem_nxt;
        end
    end

    oldest_first_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (push && !not_empty) |=> (not_empty && head == $past(push_data)))
        else $error("First entry not presented at queue head.");
endmodule : seh_err_queue

// >>> hdl/seh_top.sv
// Status event hierarchy: two status registers, standard events, status byte.
`timescale 1ns/100ps
// Operation
// - Five 16-bit parts, shared bit meaning
// - Top bit of every part reads zero
// - Live part shows present condition or summary
// - Live part read-only, unaffected by reads
// - Rising edge latches event if filter set
// - Falling edge latches event if filter set
// - Edge filters freely readable and writable
// - Events stick until read
// - Event read returns then clears; unwritable
// - Summary is OR of event AND mask
// - Summary mask readable and writable
// - Summaries feed higher register live bits
// - Error queue reads oldest entry first
// - Output-available bit follows output queue
// - Request mask and event mask act as enables
// - Request on masked status rise, bit 6 ignored
// - Status byte bits 2,3,4,5,7 carry summaries
module seh_top #(
    parameter int W = seh_pkg::DW,
    parameter int ESR_W = seh_pkg::ESR_W,
    parameter int STB_W = seh_pkg::STB_W,
    parameter int ERRQ_DEPTH = seh_pkg::ERRQ_DEPTH
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [W-2:0] questionable_summary_cond_in,
    input wire logic [W-2:0] operation_summary_cond_in,
    input wire logic [ESR_W-1:0] std_event_in,
    input wire logic err_push,
    input wire logic [W-1:0] err_code,
    input wire logic outq_not_empty,
    input wire logic [2:0] acc_sel,
    input wire logic [2:0] acc_part,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [W-1:0] acc_wdata,
    output logic [W-1:0] acc_rdata,
    output logic acc_rvalid,
    output logic [STB_W-1:0] top_status_byte,
    output logic service_request,
    output logic errq_full
);
    logic [W-1:0] questionable_summary_rdata, operation_summary_rdata, errq_head;
    logic questionable_summary, operation_summary;
    logic errq_ne;
    logic sel_questionable_summary, sel_operation_summary, sel_std, sel_stb, sel_errq;
    logic [ESR_W-1:0] esr_r, esr_nxt;
    logic [ESR_W-1:0] ese_r, ese_nxt;
    logic [STB_W-1:0] sre_r, sre_nxt;
    logic [STB_W-1:0] stb_prev_r, stb_prev_nxt;
    logic [STB_W-1:0] stb_plain, stb_rise;
    logic standard_event_summary, service_request_summary;
    logic srq_r, srq_nxt;
    logic [W-1:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;
    logic esr_rd;

    assign sel_questionable_summary = (acc_sel == seh_pkg::SEL_QUESTIONABLE_SUMMARY);
    assign sel_operation_summary = (acc_sel == seh_pkg::SEL_OPERATION_SUMMARY);
    assign sel_std = (acc_sel == seh_pkg::SEL_STD);
    assign sel_stb = (acc_sel == seh_pkg::SEL_STB);
    assign sel_errq = (acc_sel == seh_pkg::SEL_ERRQ);
    assign esr_rd = acc_rd && sel_std && (acc_part == seh_pkg::PART_EVENT);

    // Hardware conditions drive the live parts of the two lower registers.
    seh_status_reg #(.W(W)) u_questionable_summary (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .cond_in(questionable_summary_cond_in),
        .wr_en(acc_wr && sel_questionable_summary),
        .rd_en(acc_rd && sel_questionable_summary),
        .part(acc_part),
        .wdata(acc_wdata),
        .rdata(questionable_summary_rdata),
        .summary(questionable_summary)
    );

    seh_status_reg #(.W(W)) u_operation_summary (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .cond_in(operation_summary_cond_in),
        .wr_en(acc_wr && sel_operation_summary),
        .rd_en(acc_rd && sel_operation_summary),
        .part(acc_part),
        .wdata(acc_wdata),
        .rdata(operation_summary_rdata),
        .summary(operation_summary)
    );

    // Reading the queue selector pops the entry that is returned.
    seh_err_queue #(.W(W), .DEPTH(ERRQ_DEPTH)) u_errq (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .push(err_push),
        .push_data(err_code),
        .pop(acc_rd && sel_errq),
        .not_empty(errq_ne),
        .full(errq_full),
        .head(errq_head)
    );

    // Standard event register: pulses latch, a read clears.
    assign standard_event_summary = |(esr_r & ese_r);

    // Status byte without its own request bit, then with it.
    always_comb begin
        stb_plain = '0;
        stb_plain[seh_pkg::STB_ERRQ] = errq_ne;
        stb_plain[seh_pkg::STB_QUESTIONABLE_SUMMARY] = questionable_summary;
        stb_plain[seh_pkg::STB_MAV] = outq_not_empty;
        stb_plain[seh_pkg::STB_ESB] = standard_event_summary;
        stb_plain[seh_pkg::STB_OPERATION_SUMMARY] = operation_summary;
    end

    // Bit 6 of the request mask is never stored, so it cannot contribute.
    assign service_request_summary = |(stb_plain & sre_r);
    always_comb begin
        top_status_byte = stb_plain;
        top_status_byte[seh_pkg::STB_MSS] = service_request_summary;
    end
    assign stb_rise = stb_plain & ~stb_prev_r;

    always_comb begin
        esr_nxt = esr_rd ? std_event_in : (esr_r | std_event_in);
        ese_nxt = ese_r;
        sre_nxt = sre_r;
        if (acc_wr && sel_std && acc_part == seh_pkg::PART_MASK) begin
            ese_nxt = acc_wdata[ESR_W-1:0];
        end
        if (acc_wr && sel_stb && acc_part == seh_pkg::PART_MASK) begin
            sre_nxt = acc_wdata[STB_W-1:0] & seh_pkg::SRE_WMASK;
        end
        stb_prev_nxt = stb_plain;
        srq_nxt = |(stb_rise & sre_r);
    end

    // Read port: one registered answer per read strobe.
    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = acc_rd;
        if (acc_rd) begin
            case (acc_sel)
                seh_pkg::SEL_QUESTIONABLE_SUMMARY: rdata_nxt = questionable_summary_rdata;
                seh_pkg::SEL_OPERATION_SUMMARY: rdata_nxt = operation_summary_rdata;
                seh_pkg::SEL_STD: begin
                    if (acc_part == seh_pkg::PART_EVENT) begin
                        rdata_nxt = {{(W-ESR_W){1'b0}}, esr_r};
                    end else if (acc_part == seh_pkg::PART_MASK) begin
                        rdata_nxt = {{(W-ESR_W){1'b0}}, ese_r};
                    end else begin
                        rdata_nxt = '0;
                    end
                end
                seh_pkg::SEL_STB: begin
                    if (acc_part == seh_pkg::PART_MASK) begin
                        rdata_nxt = {{(W-STB_W){1'b0}}, sre_r};
                    end else begin
                        rdata_nxt = {{(W-STB_W){1'b0}}, top_status_byte};
                    end
                end
                seh_pkg::SEL_ERRQ: begin
                    rdata_nxt = errq_ne ? errq_head : '0;
                end
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            esr_r <= seh_pkg::ESR_RST;
            ese_r <= seh_pkg::ESR_RST;
            sre_r <= seh_pkg::SRE_RST;
            stb_prev_r <= '0;
            srq_r <= 1'b0;
            rdata_r <= '0;
            rvalid_r <= 1'b0;
        end else begin
            esr_r <= esr_nxt;
            ese_r <= ese_nxt;
            sre_r <= sre_nxt;
            stb_prev_r <= stb_prev_nxt;
            srq_r <= srq_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign acc_rdata = rdata_r;
    assign acc_rvalid = rvalid_r;
    assign service_request = srq_r;

    sequence masked_rise;
        ((stb_plain & ~$past(stb_plain) & sre_r) != '0);
    endsequence
    sequence std_enabled_event;
        ((std_event_in & ese_r) != '0) && !esr_rd;
    endsequence

    srq_on_rise_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        masked_rise |=> service_request)
        else $error("Masked status rise raised no request.");
    srq_cause_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        service_request |-> $past(stb_rise) != '0)
        else $error("Request raised without a status rise.");
    mask_bit6_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        sre_r[seh_pkg::STB_MSS] == 1'b0)
        else $error("Request mask bit 6 was stored.");
    mav_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        top_status_byte[seh_pkg::STB_MAV] == outq_not_empty)
        else $error("Output-available bit does not follow queue.");
    esb_raise_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        std_enabled_event |=> top_status_byte[seh_pkg::STB_ESB])
        else $error("Enabled standard event did not set summary.");
    esr_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        esr_rd |=> (esr_r == $past(std_event_in)))
        else $error("Standard event register not cleared by read.");
    read_answer_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        acc_rd |=> acc_rvalid ##1 !acc_rvalid || $past(acc_rd))
        else $error("Read answer missing or stretched.");
    questionable_summary_feed_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (acc_wr && sel_questionable_summary && acc_part == seh_pkg::PART_MASK
         && acc_wdata[W-2:0] == '0)
        |=> !top_status_byte[seh_pkg::STB_QUESTIONABLE_SUMMARY])
        else $error("Masked-off register still feeds status byte.");

    // Mask writes, queue answers and status byte shape are guarded here,
    // since the access port only shows them one read later.
    sequence sre_written;
        acc_wr && sel_stb && (acc_part == seh_pkg::PART_MASK);
    endsequence
    sequence ese_written;
        acc_wr && sel_std && (acc_part == seh_pkg::PART_MASK);
    endsequence
    sequence errq_popped;
        acc_rd && sel_errq && errq_ne;
    endsequence
    sequence operation_summary_masked_off;
        acc_wr && sel_operation_summary && (acc_part == seh_pkg::PART_MASK)
            && (acc_wdata[W-2:0] == '0);
    endsequence
    sequence mav_raised;
        $rose(outq_not_empty) && sre_r[seh_pkg::STB_MAV];
    endsequence

    sre_write_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        sre_written |=> (sre_r == ($past(acc_wdata[STB_W-1:0])
                                    & seh_pkg::SRE_WMASK)))
        else $error("Request mask write not stored as masked.");
    ese_write_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        ese_written |=> (ese_r == $past(acc_wdata[ESR_W-1:0])))
        else $error("Standard event mask write not stored.");
    esr_sticky_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        !esr_rd |=> ((esr_r & $past(esr_r)) == $past(esr_r)))
        else $error("Standard event lost without a read.");
    esr_answer_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        esr_rd |=> (acc_rdata[ESR_W-1:0] == $past(esr_r)))
        else $error("Standard event read did not return contents.");
    errq_answer_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        errq_popped |=> (acc_rdata == $past(errq_head)))
        else $error("Queue read did not return the oldest entry.");
    errq_bit_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (err_push && !errq_full) |=> top_status_byte[seh_pkg::STB_ERRQ])
        else $error("Queue entry did not set its status bit.");
    operation_summary_feed_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        operation_summary_masked_off |=> !top_status_byte[seh_pkg::STB_OPERATION_SUMMARY])
        else $error("Masked-off operation register still feeds byte.");
    srq_masked_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        ((stb_rise & sre_r) == '0) |=> !service_request)
        else $error("Request raised for a masked status bit.");
    mav_request_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        mav_raised |=> service_request)
        else $error("Output-available rise raised no request.");
    mss_sum_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        top_status_byte[seh_pkg::STB_MSS]
            == |(top_status_byte & sre_r & seh_pkg::SRE_WMASK))
        else $error("Summary bit does not match masked status byte.");
    esb_low_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (ese_r == '0) |-> !top_status_byte[seh_pkg::STB_ESB])
        else $error("Standard summary set with an empty mask.");
    rdata_msb_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        (acc_rvalid && ($past(acc_sel) != seh_pkg::SEL_ERRQ))
        |-> (acc_rdata[W-1] == 1'b0))
        else $error("Top bit of a register answer read as one.");
    stb_unused_a: assert property (@(posedge clk_sys)
        disable iff (!nrst)
        top_status_byte[1:0] == 2'h0)
        else $error("Unused status byte bits are not zero.");
endmodule : seh_top

// >>> bench/status_event_hierarchy_tb.sv
// Self-checking testbench for the status event hierarchy.
`timescale 1ns/100ps
module status_event_hierarchy_tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic [14:0] questionable_summary_cond_in = 15'h0000;
    logic [14:0] operation_summary_cond_in = 15'h0000;
    logic [7:0] std_event_in = 8'h00;
    logic err_push = 1'b0;
    logic [15:0] err_code = 16'h0000;
    logic outq_not_empty = 1'b0;
    logic [2:0] acc_sel = 3'h0;
    logic [2:0] acc_part = 3'h0;
    logic acc_wr = 1'b0;
    logic acc_rd = 1'b0;
    logic [15:0] acc_wdata = 16'h0000;
    logic [15:0] acc_rdata;
    logic acc_rvalid;
    logic [7:0] top_status_byte;
    logic service_request;
    logic errq_full;
    int n_mismatch = 0;
    int compares = 0;
    int n_srq = 0;
    int sb;

    always #5 clk_sys = ~clk_sys;

    seh_top u_dut (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .questionable_summary_cond_in(questionable_summary_cond_in),
        .operation_summary_cond_in(operation_summary_cond_in),
        .std_event_in(std_event_in),
        .err_push(err_push),
        .err_code(err_code),
        .outq_not_empty(outq_not_empty),
        .acc_sel(acc_sel),
        .acc_part(acc_part),
        .acc_wr(acc_wr),
        .acc_rd(acc_rd),
        .acc_wdata(acc_wdata),
        .acc_rdata(acc_rdata),
        .acc_rvalid(acc_rvalid),
        .top_status_byte(top_status_byte),
        .service_request(service_request),
        .errq_full(errq_full)
    );

    // The request is a one-cycle pulse, so it is counted at every falling
    // edge, where it has long settled.
    always @(negedge clk_sys) begin
        if (service_request === 1'b1) begin
            n_srq <= n_srq + 1;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    task automatic conclude;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic bit_chk(input string what, input int idx,
                           input logic exp);
        chk(what, {15'h0000, top_status_byte[idx]}, {15'h0000, exp});
    endtask : bit_chk

    // Strobes go high and low on separate falling edges so that back to
    // back calls never assign a strobe twice in one time step.
    task automatic reg_wr(input logic [2:0] sel, input logic [2:0] part,
                          input logic [15:0] data);
        acc_sel = sel;
        acc_part = part;
        acc_wdata = data;
        acc_wr = 1'b1;
        tick(1);
        acc_wr = 1'b0;
        tick(1);
    endtask : reg_wr

    task automatic rd_chk(input logic [2:0] sel, input logic [2:0] part,
                          input logic [15:0] exp, input string what);
        int i;
        acc_sel = sel;
        acc_part = part;
        acc_rd = 1'b1;
        tick(1);
        acc_rd = 1'b0;
        for (i = 0; i < 4 && acc_rvalid !== 1'b1; i++) begin
            tick(1);
        end
        if (acc_rvalid !== 1'b1) begin
            n_mismatch++;
            $display("ERROR read answer expected 1 seen 0");
            conclude();
        end else begin
            chk(what, acc_rdata, exp);
            tick(1);
        end
    endtask : rd_chk

    initial begin
        tick(10);
        nrst = 1'b1;
        tick(1);
        for (logic [2:0] r = 3'h0; r < 3'h2; r++) begin
            rd_chk(r, seh_pkg::PART_RISE, 16'h7FFF, "rise rst");
            rd_chk(r, seh_pkg::PART_FALL, 16'h0000, "fall rst");
            rd_chk(r, seh_pkg::PART_EVENT, 16'h0000, "event rst");
            rd_chk(r, seh_pkg::PART_MASK, 16'h0000, "mask rst");
            reg_wr(r, seh_pkg::PART_RISE, 16'hFFFF);
            rd_chk(r, seh_pkg::PART_RISE, 16'h7FFF, "rise rw");
            reg_wr(r, seh_pkg::PART_FALL, 16'hD555);
            rd_chk(r, seh_pkg::PART_FALL, 16'h5555, "fall rw");
            rd_chk(r, seh_pkg::PART_FALL, 16'h5555, "fall reread");
            reg_wr(r, seh_pkg::PART_FALL, 16'h0000);
            reg_wr(r, seh_pkg::PART_MASK, 16'hFFFF);
            rd_chk(r, seh_pkg::PART_MASK, 16'h7FFF, "mask rw");
            reg_wr(r, seh_pkg::PART_MASK, 16'h0000);
        end
        rd_chk(seh_pkg::SEL_STB, seh_pkg::PART_MASK, 16'h0000, "sre rst");
        questionable_summary_cond_in = 15'h1234;
        tick(2);
        rd_chk(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_LIVE, 16'h1234, "live");
        reg_wr(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_LIVE, 16'h7FFF);
        rd_chk(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_LIVE, 16'h1234, "live ro");
        rd_chk(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_EVENT, 16'h1234, "rise ev");
        rd_chk(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_EVENT, 16'h0000, "ev clr");
        reg_wr(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_EVENT, 16'h7FFF);
        rd_chk(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_EVENT, 16'h0000, "ev ro");
        reg_wr(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_RISE, 16'h0000);
        reg_wr(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_FALL, 16'h00FF);
        questionable_summary_cond_in = 15'h0000;
        tick(2);
        rd_chk(seh_pkg::SEL_QUESTIONABLE_SUMMARY, seh_pkg::PART_EVENT, 16'h0034, "fall ev");
        reg_wr(seh_pkg::SEL_STB, seh_pkg::PART_MASK, 16'h00FF);
        rd_chk(seh_pkg::SEL_STB, seh_pkg::PART_MASK, 16'h00BF, "sre bit6");
        for (logic [2:0] r = 3'h0; r < 3'h2; r++) begin
            sb = (r == 3'h0) ? seh_pkg::STB_QUESTIONABLE_SUMMARY : seh_pkg::STB_OPERATION_SUMMARY;
            reg_wr(r, seh_pkg::PART_RISE, 16'h0004);
            reg_wr(r, seh_pkg::PART_FALL, 16'h0000);
            reg_wr(r, seh_pkg::PART_MASK, 16'h0004);
            questionable_summary_cond_in = (r == 3'h0) ? 15'h0004 : 15'h0000;
            operation_summary_cond_in = (r == 3'h1) ? 15'h0004 : 15'h0000;
            tick(2);
            bit_chk("summary set", sb, 1'b1);
            bit_chk("mss set", seh_pkg::STB_MSS, 1'b1);
            rd_chk(r, seh_pkg::PART_EVENT, 16'h0004, "sum ev");
            bit_chk("summary clr", sb, 1'b0);
        end
        questionable_summary_cond_in = 15'h0000;
        operation_summary_cond_in = 15'h0000;
        outq_not_empty = 1'b1;
        tick(1);
        bit_chk("mav set", seh_pkg::STB_MAV, 1'b1);
        outq_not_empty = 1'b0;
        tick(1);
        bit_chk("mav clr", seh_pkg::STB_MAV, 1'b0);
        reg_wr(seh_pkg::SEL_STD, seh_pkg::PART_MASK, 16'h0001);
        std_event_in = 8'h01;
        tick(1);
        std_event_in = 8'h00;
        tick(1);
        bit_chk("esb set", seh_pkg::STB_ESB, 1'b1);
        rd_chk(seh_pkg::SEL_STD, seh_pkg::PART_EVENT, 16'h0001, "esr");
        bit_chk("esb clr", seh_pkg::STB_ESB, 1'b0);
        for (int i = 0; i < seh_pkg::ERRQ_DEPTH; i++) begin
            err_code = 16'hA000 + 16'(i);
            err_push = 1'b1;
            tick(1);
        end
        err_push = 1'b0;
        tick(1);
        chk("errq full", {15'h0000, errq_full}, 16'h0001);
        bit_chk("errq bit", seh_pkg::STB_ERRQ, 1'b1);
        for (int i = 0; i < seh_pkg::ERRQ_DEPTH; i++) begin
            rd_chk(seh_pkg::SEL_ERRQ, seh_pkg::PART_LIVE,
                   16'hA000 + 16'(i), "errq order");
        end
        rd_chk(seh_pkg::SEL_ERRQ, seh_pkg::PART_LIVE, 16'h0000, "errq empty");
        bit_chk("errq clr", seh_pkg::STB_ERRQ, 1'b0);
        // Quest, operation_summary, message, standard event and queue each rose once.
        chk("srq count", n_srq[15:0], 16'h0005);
        reg_wr(seh_pkg::SEL_STB, seh_pkg::PART_MASK, 16'h0000);
        outq_not_empty = 1'b1;
        tick(3);
        chk("srq masked", n_srq[15:0], 16'h0005);
        bit_chk("mss masked", seh_pkg::STB_MSS, 1'b0);
        rd_chk(seh_pkg::SEL_STB, seh_pkg::PART_LIVE,
               16'h0010, "stb read");
        conclude();
    end
endmodule : status_event_hierarchy_tb
